/* design/emb_bus_ctrl.v */
/*
  external program/data memory bus engine: multiplexed low address/data port,
  high address port, latch, fetch, load and store strobes, wait input, two
  address pointers and the on-chip data ram.
  assumes requests arrive synchronous to clk through the request fifo and
  that the board ties the boot source select low.
*/
// Behaviour
// - one machine cycle is four clocks; every strobe is timed from it
// - reset takes effect after rst held high two machine cycles
// - fetches and code table reads drive the code fetch strobe low
// - address latch strobe pulses while low address is on the shared port
// - low address then data share the low port in each access
// - high address stands on the high port for the whole access
// - store strobe serves external data writes
// - load strobe serves external data reads
// - wait input, when enabled, lengthens external data accesses
// - external data moves last two to nine machine cycles as programmed
// - 1KB on-chip data ram sits at 0000h to 03ffh
// - on-chip ram answers only external data moves
// - on-chip ram used only when enabled, else accesses go to the bus
// - two independent address pointers may source data move addresses
// - opcode a5h decrements the selected pointer by one
// - addresses above 03ffh always use the external bus
// - on-chip ram enable clears on reset
`timescale 1ns/1ps
`include "emb_regs.vh"

module emb_bus_ctrl #(
	parameter FIFO_DEPTH = `EMB_FIFO_DEPTH
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire reqValid,
	output wire reqReady,
	input wire [1:0] reqKind,
	input wire reqUsePtr,
	input wire [15:0] reqAddr,
	input wire [7:0] reqData,
	output reg rdValid,
	output reg [7:0] rdData,
	output wire busy,
	input wire onchipXramEnableSet,
	input wire onchipXramEnableVal,
	output reg onchipXramEnable,
	input wire [2:0] stretchSel,
	input wire waitEnable,
	input wire waitIn,
	input wire ptrSel,
	input wire ptrLoad,
	input wire [15:0] ptrLoadVal,
	input wire ptrInc,
	input wire opValid,
	input wire [7:0] opcode,
	output reg [15:0] ptrOut,
	output reg [7:0] addrDataOut,
	output reg addrDataOe,
	input wire [7:0] addrDataIn,
	output reg [7:0] highAddrOut,
	output reg addrLatch,
	output reg codeFetchStrobeN,
	output reg loadStrobeN,
	output reg storeStrobeN
);
	// ----------------------------------------------------------------
	// states and helpers
	// ----------------------------------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_ADDR = 2'h1;
	localparam ST_STRB = 2'h2;
	localparam ST_IRAM = 2'h3;
	localparam integer RST_SH_N = `EMB_RST_CLKS - 1;
	localparam integer LAST_N = `EMB_CLK_PER_MC - 1;
	localparam integer XMIN_N = `EMB_XMOVE_MIN_MC;
	localparam [1:0] LAST_PH = LAST_N[1:0];
	localparam [3:0] XMOVE_MIN = XMIN_N[3:0];

	function onchip;
		input [15:0] a;
		input en;
		input [1:0] k;
		begin
			onchip = en && (a <= `EMB_XRAM_TOP) && k[1];
		end
	endfunction

	// ----------------------------------------------------------------
	// reset qualification
	// ----------------------------------------------------------------
	reg [RST_SH_N-1:0] rstSh_r;
	wire coreRst;

	// a shift of rst samples needs no reset of its own, so it settles from power-up
	always @(posedge clk) begin
		if (ce) begin
			rstSh_r <= {rstSh_r[RST_SH_N-2:0], rst};
		end
	end
	// short reset pulses are ignored; the core only resets after the hold
	assign coreRst = rst && (&rstSh_r);

	// ----------------------------------------------------------------
	// request fifo
	// ----------------------------------------------------------------
	reg [1:0] state_r;
	reg [1:0] phase_r;
	wire fifoValid;
	wire [`EMB_REQ_W-1:0] fifoData;
	wire popReady;

	assign popReady = (state_r == ST_IDLE) && (phase_r == LAST_PH);

	emb_fifo #(
		.W(`EMB_REQ_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(coreRst),
		.ce(ce),
		.inValid(reqValid),
		.inReady(reqReady),
		.inData({reqKind, reqUsePtr, reqAddr, reqData}),
		.outValid(fifoValid),
		.outReady(popReady),
		.outData(fifoData)
	);

	wire [1:0] popKind = fifoData[`EMB_REQ_KIND_HI:`EMB_REQ_KIND_LO];
	wire popUsePtr = fifoData[`EMB_REQ_PTR];
	wire [15:0] popAddrRaw = fifoData[`EMB_REQ_ADDR_HI:`EMB_REQ_ADDR_LO];
	wire [7:0] popData = fifoData[`EMB_REQ_DATA_HI:`EMB_REQ_DATA_LO];
	wire pop = ce && fifoValid && popReady;

	// ----------------------------------------------------------------
	// address pointers
	// ----------------------------------------------------------------
	reg [15:0] ptr0_r;
	reg [15:0] ptr1_r;
	wire [15:0] selPtr = ptrSel ? ptr1_r : ptr0_r;
	// only data moves may take their address from a pointer
	wire [15:0] popAddr = (popUsePtr && popKind[1]) ? selPtr : popAddrRaw;
	wire [15:0] ptrNxt = ptrLoad ? ptrLoadVal :
		(opValid && opcode == `EMB_OP_DEC_PTR) ? selPtr - 16'h0001 :
		ptrInc ? selPtr + 16'h0001 : selPtr;

	always @(posedge clk) begin
		if (coreRst) begin
			ptr0_r <= 16'h0000;
			ptr1_r <= 16'h0000;
			ptrOut <= 16'h0000;
		end else if (ce) begin
			if (ptrSel) begin
				ptr1_r <= ptrNxt;
			end else begin
				ptr0_r <= ptrNxt;
			end
			ptrOut <= ptrNxt;
		end
	end

	// ----------------------------------------------------------------
	// control bits
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (coreRst) begin
			onchipXramEnable <= 1'b0;
		end else if (ce && onchipXramEnableSet) begin
			onchipXramEnable <= onchipXramEnableVal;
		end
	end

	// ----------------------------------------------------------------
	// on-chip ram
	// ----------------------------------------------------------------
	reg [1:0] kind_r;
	reg [15:0] addr_r;
	reg [7:0] wdata_r;
	reg [3:0] mcLeft_r;
	wire [7:0] ramRd;
	wire ramEn = ce && (state_r == ST_IRAM) && (phase_r == 2'h0);

	emb_xram #(
		.AW(`EMB_XRAM_AW),
		.W(8)
	) u_xram (
		.clk(clk),
		.en(ramEn),
		.we(kind_r == `EMB_KIND_XWR),
		.addr(addr_r[`EMB_XRAM_AW-1:0]),
		.wrData(wdata_r),
		.rdData(ramRd)
	);

	// ----------------------------------------------------------------
	// access sequencer
	// ----------------------------------------------------------------
	wire lastPh = (phase_r == LAST_PH);
	wire lastMc = (mcLeft_r == 4'h1);
	// a held wait freezes the final strobe machine cycle
	wire waitHold = waitEnable && waitIn && kind_r[1];
	// decided on the edge that would release the strobe, so it never drops and returns
	reg waitHeld_r;
	assign busy = (state_r != ST_IDLE);

	always @(posedge clk) begin
		if (coreRst) begin
			state_r <= ST_IDLE;
			phase_r <= 2'h0;
			kind_r <= `EMB_KIND_FETCH;
			addr_r <= 16'h0000;
			wdata_r <= 8'h00;
			mcLeft_r <= 4'h0;
			rdValid <= 1'b0;
			rdData <= 8'h00;
			waitHeld_r <= 1'b0;
		end else if (ce) begin
			phase_r <= phase_r + 2'h1;
			waitHeld_r <= waitHold;
			rdValid <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				if (pop) begin
					kind_r <= popKind;
					addr_r <= popAddr;
					wdata_r <= popData;
					// data moves take stretch+1 strobe cycles after the address cycle
					mcLeft_r <= popKind[1] ? XMOVE_MIN - 4'h1 + {1'b0, stretchSel} : 4'h1;
					state_r <= onchip(popAddr, onchipXramEnable, popKind) ? ST_IRAM : ST_ADDR;
				end
			end
			ST_ADDR: begin
				if (lastPh) begin
					state_r <= ST_STRB;
				end
			end
			ST_STRB: begin
				if (lastPh) begin
					if (!lastMc) begin
						mcLeft_r <= mcLeft_r - 4'h1;
					end else if (!waitHeld_r) begin
						if (kind_r != `EMB_KIND_XWR) begin
							rdData <= addrDataIn;
							rdValid <= 1'b1;
						end
						state_r <= ST_IDLE;
					end
				end
			end
			ST_IRAM: begin
				if (lastPh) begin
					if (kind_r != `EMB_KIND_XWR) begin
						rdData <= ramRd;
						rdValid <= 1'b1;
					end
					state_r <= ST_IDLE;
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pin drive, registered from next state and phase
	// ----------------------------------------------------------------
	// pins change on the edge that enters the phase they belong to
	reg [1:0] stN;
	reg [1:0] phN;
	reg strbEnd;

	always @* begin
		phN = phase_r + 2'h1;
		stN = state_r;
		strbEnd = 1'b0;
		if (state_r == ST_IDLE && pop) begin
			stN = onchip(popAddr, onchipXramEnable, popKind) ? ST_IRAM : ST_ADDR;
		end else if (state_r == ST_ADDR && lastPh) begin
			stN = ST_STRB;
		end else if (state_r == ST_STRB && lastPh && lastMc && !waitHeld_r) begin
			stN = ST_IDLE;
		end else if (state_r == ST_IRAM && lastPh) begin
			stN = ST_IDLE;
		end
		// strobe releases one phase before the end so data and address hold
		if (stN == ST_STRB && phN == LAST_PH && lastMc && !waitHold) begin
			strbEnd = 1'b1;
		end
	end

	wire [15:0] busAddr = (state_r == ST_IDLE) ? popAddr : addr_r;
	wire [1:0] busKind = (state_r == ST_IDLE) ? popKind : kind_r;

	always @(posedge clk) begin
		if (coreRst) begin
			addrDataOut <= 8'h00;
			addrDataOe <= 1'b0;
			highAddrOut <= 8'h00;
			addrLatch <= 1'b0;
			codeFetchStrobeN <= 1'b1;
			loadStrobeN <= 1'b1;
			storeStrobeN <= 1'b1;
		end else if (ce) begin
			addrLatch <= (stN == ST_ADDR) && (phN[1] == 1'b0);
			if (stN == ST_ADDR) begin
				highAddrOut <= busAddr[15:8];
				addrDataOut <= busAddr[7:0];
				addrDataOe <= (phN != LAST_PH) || (busKind == `EMB_KIND_XWR);
			end else if (stN == ST_STRB) begin
				addrDataOut <= wdata_r;
				addrDataOe <= (kind_r == `EMB_KIND_XWR);
			end else begin
				addrDataOe <= 1'b0;
			end
			codeFetchStrobeN <= !(stN == ST_STRB && !kind_r[1] && !strbEnd);
			loadStrobeN <= !(stN == ST_STRB && kind_r == `EMB_KIND_XRD && !strbEnd);
			storeStrobeN <= !(stN == ST_STRB && kind_r == `EMB_KIND_XWR && !strbEnd);
		end
	end
endmodule // emb_bus_ctrl

/* design/emb_regs.vh */
/*
  constants of the external memory bus block: machine cycle shape, reset hold,
  access kinds, on-chip data window and the pointer-decrement opcode.
  assumes nothing; definitions only.
*/
`ifndef EMB_REGS_VH
`define EMB_REGS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define EMB_CLK_PER_MC 4
`define EMB_RST_MC 2
`define EMB_RST_CLKS (`EMB_CLK_PER_MC * `EMB_RST_MC)
`define EMB_XMOVE_MIN_MC 2
`define EMB_XMOVE_MAX_MC 9

// ----------------------------------------------------------------
// access kinds in a request word
// ----------------------------------------------------------------
`define EMB_KIND_FETCH 2'h0
`define EMB_KIND_CTAB 2'h1
`define EMB_KIND_XRD 2'h2
`define EMB_KIND_XWR 2'h3

// ----------------------------------------------------------------
// request word layout: {kind, usePtr, addr, data}
// ----------------------------------------------------------------
`define EMB_REQ_W 27
`define EMB_REQ_KIND_HI 26
`define EMB_REQ_KIND_LO 25
`define EMB_REQ_PTR 24
`define EMB_REQ_ADDR_HI 23
`define EMB_REQ_ADDR_LO 8
`define EMB_REQ_DATA_HI 7
`define EMB_REQ_DATA_LO 0

// ----------------------------------------------------------------
// on-chip data ram and opcodes
// ----------------------------------------------------------------
`define EMB_XRAM_TOP 16'h03ff
`define EMB_XRAM_AW 10
`define EMB_OP_DEC_PTR 8'ha5
`define EMB_FIFO_DEPTH 32

`endif

/* design/emb_fifo.v */
/*
  synchronous fifo with valid/ready on both sides and honest full and empty.
  assumes one clock, a clock enable that freezes it and a synchronous reset.
*/
`timescale 1ns/1ps

module emb_fifo #(
	parameter W = 27,
	parameter D = 32
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire inValid,
	output wire inReady,
	input wire [W-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [W-1:0] outData
);
	localparam AW = $clog2(D);

	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wrPtr_r;
	reg [AW-1:0] rdPtr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	assign inReady = (count_r != D[AW:0]);
	assign outValid = (count_r != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_r];
	assign push = ce & inValid & inReady;
	assign pop = ce & outValid & outReady;

	always @(posedge clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			wrPtr_r <= {AW{1'b0}};
			rdPtr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wrPtr_r <= (wrPtr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= (rdPtr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule // emb_fifo

/* design/emb_xram.v */
/*
  on-chip data ram, single port, synchronous read one cycle after the address.
  assumes the controller holds address and write strobe for one clock.
*/
`timescale 1ns/1ps

module emb_xram #(
	parameter AW = 10,
	parameter W = 8
) (
	input wire clk,
	input wire en,
	input wire we,
	input wire [AW-1:0] addr,
	input wire [W-1:0] wrData,
	output reg [W-1:0] rdData
);
	reg [W-1:0] mem [0:(1<<AW)-1];

	always @(posedge clk) begin
		if (en) begin
			if (we) begin
				mem[addr] <= wrData;
			end
			rdData <= mem[addr];
		end
	end
endmodule // emb_xram

/* tb/emb_bus_chk.sv */
/*
  bus engine checker: pin relations of latch, strobes, port drive and read pulse.
  assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/1ps

module emb_bus_chk (
	input wire clk,
	input wire rst,
	input wire addrLatch,
	input wire addrDataOe,
	input wire [7:0] highAddrOut,
	input wire codeFetchStrobeN,
	input wire loadStrobeN,
	input wire storeStrobeN,
	input wire rdValid,
	input wire waitEnable,
	input wire waitIn
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_latchTail; addrLatch ##1 !addrLatch; endsequence
	sequence s_waitSeen; $fell(loadStrobeN) ##2 (waitEnable && waitIn); endsequence
	property p_latch; $rose(addrLatch) |=> s_latchTail; endproperty
	property p_latchOe; addrLatch |-> addrDataOe; endproperty
	property p_fetch; $fell(codeFetchStrobeN) |-> !codeFetchStrobeN[*3] ##1 codeFetchStrobeN;
	endproperty
	property p_loadMin; $fell(loadStrobeN) |-> !loadStrobeN[*3]; endproperty
	property p_wait; s_waitSeen |=> !loadStrobeN; endproperty
	property p_rd; $rose(loadStrobeN) |=> rdValid; endproperty
	property p_excl; loadStrobeN || storeStrobeN; endproperty
	property p_storeOe; (!storeStrobeN || $rose(storeStrobeN)) |-> addrDataOe; endproperty
	property p_loadOe; !loadStrobeN |-> !addrDataOe; endproperty
	property p_high; !loadStrobeN |-> $stable(highAddrOut); endproperty
	a_latch: assert property (p_latch) else $error("latch pulse");
	a_latchOe: assert property (p_latchOe) else $error("latch undriven");
	a_fetch: assert property (p_fetch) else $error("fetch strobe");
	a_loadMin: assert property (p_loadMin) else $error("short load");
	a_wait: assert property (p_wait) else $error("wait ignored");
	a_rd: assert property (p_rd) else $error("no read pulse");
	a_excl: assert property (p_excl) else $error("both strobes");
	a_storeOe: assert property (p_storeOe) else $error("write data");
	a_loadOe: assert property (p_loadOe) else $error("read contention");
	a_high: assert property (p_high) else $error("high address moved");
endmodule // emb_bus_chk

bind emb_bus_ctrl emb_bus_chk emb_bus_chk_i (.clk(clk), .rst(rst), .addrLatch(addrLatch),
	.addrDataOe(addrDataOe), .highAddrOut(highAddrOut), .codeFetchStrobeN(codeFetchStrobeN),
	.loadStrobeN(loadStrobeN), .storeStrobeN(storeStrobeN), .rdValid(rdValid),
	.waitEnable(waitEnable), .waitIn(waitIn));

/* tb/emb_mem_model.sv */
/*
  far side: address latch, code rom and data ram on the shared port.
  assumes the engine's pins; wait rises for holdClks once a data strobe falls.
*/
`timescale 1ns/1ps

module emb_mem_model (
	input wire clk,
	input wire [7:0] addrDataOut,
	input wire addrDataOe,
	output wire [7:0] busLevel,
	input wire [7:0] highAddrOut,
	input wire addrLatch,
	input wire codeFetchStrobeN,
	input wire loadStrobeN,
	input wire storeStrobeN,
	input wire [7:0] holdClks,
	output wire waitIn
);
	reg [7:0] ram [0:65535];
	reg [7:0] latchLo_r, outData_r;
	reg [7:0] last_r = 8'h00;
	reg [7:0] cnt_r = 8'h00;
	reg hold_r = 1'b0;
	reg idle_r = 1'b1;
	reg latchPrev_r = 1'b0;
	integer accCount = 0;
	wire [15:0] addr = {highAddrOut, latchLo_r};
	wire strobeLow = !codeFetchStrobeN || !loadStrobeN;
	wire idle = loadStrobeN && storeStrobeN;
	// a released port toggles, so a stale byte can never pass as data
	assign busLevel = addrDataOe ? addrDataOut : (strobeLow || hold_r) ? outData_r : ~last_r;
	assign waitIn = cnt_r != 8'h00;
	always @(posedge clk) begin
		last_r <= busLevel;
		latchPrev_r <= addrLatch;
		if (addrLatch)
			latchLo_r <= addrDataOut;
		if (addrLatch && !latchPrev_r)
			accCount <= accCount + 1;
		if (strobeLow)
			// the board keeps the boot source pin low, so every fetch comes from this rom
			outData_r <= !codeFetchStrobeN ? (addr[7:0] ^ addr[15:8] ^ 8'h5a) : ram[addr];
		// data stays one clock past strobe release, as a memory hold time
		hold_r <= strobeLow;
		if (!storeStrobeN)
			ram[addr] <= addrDataOut;
		idle_r <= idle;
		if (idle_r && !idle)
			cnt_r <= holdClks;
		else if (waitIn)
			cnt_r <= cnt_r - 8'h01;
	end
endmodule // emb_mem_model

/* tb/testbench.sv */
/*
  bench for the bus engine: one task per scenario, judged inline.
  assumes the far-side model and the bound checker.
*/
`timescale 1ns/1ps

module testbench;
	reg clk, rst, reqValid, reqUsePtr, enSet, enVal, waitEnable;
	reg ptrSel, ptrLoad, ptrInc, opValid, refused, ce;
	reg [1:0] reqKind;
	reg [2:0] stretchSel;
	reg [7:0] reqData, opcode, holdClks, got;
	reg [15:0] reqAddr, ptrLoadVal;
	wire reqReady, rdValid, busy, onEn, oe, addrLatch, cfN, ldN, stN, waitIn;
	wire [7:0] rdData, adOut, adIn, hiOut;
	wire [15:0] ptrOut;
	integer failures = 0, samples_checked = 0, cycles = 0, n, i, c;
	emb_bus_ctrl emb_bus_ctrl_i (.clk(clk), .rst(rst), .ce(ce), .reqValid(reqValid),
		.reqReady(reqReady), .reqKind(reqKind), .reqUsePtr(reqUsePtr), .reqAddr(reqAddr),
		.reqData(reqData), .rdValid(rdValid), .rdData(rdData), .busy(busy),
		.onchipXramEnableSet(enSet), .onchipXramEnableVal(enVal), .onchipXramEnable(onEn),
		.stretchSel(stretchSel), .waitEnable(waitEnable), .waitIn(waitIn), .ptrSel(ptrSel),
		.ptrLoad(ptrLoad), .ptrLoadVal(ptrLoadVal), .ptrInc(ptrInc), .opValid(opValid),
		.opcode(opcode), .ptrOut(ptrOut), .addrDataOut(adOut), .addrDataOe(oe),
		.addrDataIn(adIn), .highAddrOut(hiOut), .addrLatch(addrLatch),
		.codeFetchStrobeN(cfN), .loadStrobeN(ldN), .storeStrobeN(stN));
	emb_mem_model emb_mem_model_i (.clk(clk), .addrDataOut(adOut), .addrDataOe(oe),
		.busLevel(adIn), .highAddrOut(hiOut), .addrLatch(addrLatch), .codeFetchStrobeN(cfN),
		.loadStrobeN(ldN), .storeStrobeN(stN), .holdClks(holdClks), .waitIn(waitIn));
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (rdValid === 1'b1)
			got <= rdData;
		if (cycles == 20000) begin
			failures = failures + 1;
			complete_run;
		end
	end
	task step;
		@(posedge clk);
		#2;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task req(input [1:0] k, input p, input [15:0] a, input [7:0] d);
		reqKind = k;
		reqUsePtr = p;
		reqAddr = a;
		reqData = d;
		reqValid = 1;
		while (reqReady !== 1'b1) begin
			refused = 1;
			step;
		end
		step;
	endtask
	task drain;
		n = 0;
		while (busy !== 1'b1 && n < 20) begin
			step;
			n = n + 1;
		end
		while (busy !== 1'b0 && n < 600) begin
			step;
			n = n + 1;
		end
		step;
		chk(n < 600, 1);
	endtask
	task acc(input [1:0] k, input p, input [15:0] a, input [7:0] d);
		req(k, p, a, d);
		reqValid = 0;
		drain;
	endtask
	task strobeLen;
		c = 0;
		while (ldN !== 1'b0 && c < 40) begin
			step;
			c = c + 1;
		end
		c = 0;
		while (ldN === 1'b0 && c < 99) begin
			step;
			c = c + 1;
		end
	endtask
	task onchip(input v);
		enVal = v;
		enSet = 1;
		step;
		enSet = 0;
	endtask
	task t_onchip;
		chk(onEn, 0);
		onchip(1);
		i = emb_mem_model_i.accCount;
		acc(3, 0, 16'h03ff, 8'ha7);
		acc(2, 0, 16'h03ff, 8'h00);
		chk(got, 8'ha7);
		chk(emb_mem_model_i.accCount, i);
		acc(0, 0, 16'h0010, 8'h00);
		chk(emb_mem_model_i.accCount, i + 1);
		acc(3, 0, 16'h0400, 8'h11);
		chk(emb_mem_model_i.ram[16'h0400], 8'h11);
		onchip(0);
		acc(3, 0, 16'h03ff, 8'h22);
		chk(emb_mem_model_i.ram[16'h03ff], 8'h22);
	endtask
	task t_kinds;
		acc(0, 0, 16'h1234, 8'h00);
		chk(got, 8'h12 ^ 8'h34 ^ 8'h5a);
		chk(emb_mem_model_i.latchLo_r, 8'h34);
		acc(1, 0, 16'hbeef, 8'h00);
		chk(got, 8'hbe ^ 8'hef ^ 8'h5a);
		acc(3, 0, 16'h4401, 8'h3c);
		chk(emb_mem_model_i.ram[16'h4401], 8'h3c);
		acc(2, 0, 16'h4401, 8'h00);
		chk(got, 8'h3c);
	endtask
	task t_stretch;
		for (i = 0; i < 8; i = i + 1) begin
			stretchSel = i[2:0];
			req(2, 0, 16'h4401, 8'h00);
			reqValid = 0;
			strobeLen;
			chk(c, 4 * (i + 1) - 1);
			drain;
		end
		stretchSel = 0;
	endtask
	task t_wait;
		holdClks = 10;
		req(2, 0, 16'h4401, 8'h00);
		reqValid = 0;
		strobeLen;
		chk(c, 3);
		drain;
		waitEnable = 1;
		req(2, 0, 16'h4401, 8'h00);
		reqValid = 0;
		strobeLen;
		chk(c, 15);
		drain;
		waitEnable = 0;
	endtask
	task t_reset;
		onchip(1);
		rst = 1;
		repeat (5) step;
		rst = 0;
		step;
		chk(onEn, 1);
		rst = 1;
		repeat (8) step;
		rst = 0;
		step;
		chk(onEn, 0);
	endtask
	task t_ptr;
		ptrSel = 1;
		ptrLoadVal = 16'h0100;
		ptrLoad = 1;
		step;
		ptrLoad = 0;
		opcode = 8'ha5;
		opValid = 1;
		step;
		opValid = 0;
		step;
		chk(ptrOut, 16'h00ff);
		ptrSel = 0;
		ptrLoadVal = 16'h2000;
		ptrLoad = 1;
		step;
		ptrLoad = 0;
		ptrInc = 1;
		step;
		ptrInc = 0;
		acc(3, 1, 16'h0000, 8'h5e);
		chk(emb_mem_model_i.ram[16'h2001], 8'h5e);
		ptrSel = 1;
		acc(3, 1, 16'h0000, 8'h6f);
		chk(emb_mem_model_i.ram[16'h00ff], 8'h6f);
	endtask
	task t_fifo;
		waitEnable = 1;
		holdClks = 12;
		refused = 0;
		for (i = 0; i < 36; i = i + 1)
			req(3, 0, {8'h60, i[7:0]}, i[7:0]);
		reqValid = 0;
		n = 0;
		while (emb_mem_model_i.ram[16'h6023] !== 8'h23 && n < 9000) begin
			step;
			n = n + 1;
		end
		drain;
		chk(refused, 1);
		chk(reqReady, 1);
		for (i = 0; i < 36; i = i + 1)
			chk(emb_mem_model_i.ram[{8'h60, i[7:0]}], i[7:0]);
		waitEnable = 0;
	endtask
	task t_freeze;
		acc(3, 0, 16'h4402, 8'h96);
		stretchSel = 3'h7;
		req(2, 0, 16'h4402, 8'h00);
		reqValid = 0;
		c = 0;
		while (ldN !== 1'b0 && c < 40) begin
			step;
			c = c + 1;
		end
		// a frozen engine must outlast the longest strobe
		ce = 0;
		repeat (40) step;
		chk(ldN, 0);
		chk(busy, 1);
		ce = 1;
		drain;
		chk(got, 8'h96);
		stretchSel = 3'h0;
	endtask
	task complete_run;
		if (failures == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		{rst, reqValid, reqUsePtr, enSet, enVal, waitEnable} = 6'h20;
		{ptrSel, ptrLoad, ptrInc, opValid, refused} = 5'h00;
		ce = 1;
		{reqKind, stretchSel, reqData, opcode, holdClks} = 29'h0;
		{reqAddr, ptrLoadVal} = 32'h0;
		// two machine cycles are needed, so the hold runs past eight clocks
		repeat (10) step;
		rst = 0;
		step;
		t_onchip;
		t_kinds;
		t_stretch;
		t_freeze;
		t_wait;
		t_reset;
		t_ptr;
		t_fifo;
		complete_run;
	end
endmodule // testbench
